// File: src/twcp_top.sv
// Two-wire serial control slave with configuration registers
//
// Contract
// - Load-sense field zero disables; bits 2,1,0 enable jack, right, left pins.
// - Full shutdown bit at power_management overrides every other enable.
// - Converters are usable only while the digital core bit is set.
// - Line out and each DAC and ADC channel have their own enable.
// - Port works with bus clocks up to 400 kHz; master stays below.
// - Each byte is eight bits, MSB first, plus one acknowledge clock.
// - Data line is open drain: only pulled low or released.
// - Data stable while clock high; changes then are control conditions.
// - START is data falling, STOP data rising, both with clock high.
// - Repeated START keeps frame alive and decodes a new address byte.
// - STOP aborts anywhere, except within the same clock-high as START.
// - Address 0010000 in upper bits; low bit one means read.
// - A received byte is acknowledged by holding data low all ninth clock.
// - Second byte of a write frame loads the register pointer, acknowledged.
// - Further bytes go to the pointed register, acknowledged, pointer advances.
// - After a read address, register bytes shift out one bit per clock.
// - Plain START then read resets pointer to zero; advances per byte.
// - Pointer preset by write, repeated START, read returns chosen register.
`timescale 1ns/100ps
module twcp_top
  import twcp_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      full_shutdown_out,
  output logic      digital_core_on_out,
  output logic      line_out_on_out,
  output logic      left_dac_on_out,
  output logic      right_dac_on_out,
  output logic      left_adc_on_out,
  output logic      right_adc_on_out,
  output logic      jack_sense_pin_sense_out,
  output logic      right_phones_out_sense_out,
  output logic      left_phones_out_sense_out,
  output logic      addressed_out
);

  twcp_reg_if rif ();

  // Synchronised pins and their previous values
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_d_r;
  logic        sda_d_r;

  // Bus events
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        stop_ok;

  // Protocol state
  twcp_state_e state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  tx_sh_r;
  logic [7:0]  ptr_r;
  logic        ptr_set_r;
  logic        rw_r;
  logic        mack_r;
  logic        in_frame_r;
  logic        rep_r;
  logic        start_hi_r;
  logic        sda_oe_r;

  // Decoded moments within a byte
  logic        byte_end;
  logic        addr_done;
  logic        addr_ok;
  logic        tx_load;

  // Address match on a completed address byte
  function automatic logic addr_hit(input logic [7:0] b);
    return b[7:1] == DEV_ADDR;
  endfunction

  // Clock line is only ever sampled; it is never driven here
  twcp_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .d_in   ({scl_in, sda_in}),
    .q_out  (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  twcp_regfile #(
    .NREG (REG_COUNT)
  ) u_regs (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .bus    (rif.rf)
  );

  // Previous sample of both lines for edge finding
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce_in) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Both lines share one synchroniser delay, so their order is kept;
  // at 50 MHz a 400 kHz clock high lasts dozens of samples
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  // Data moving while clock high is a condition, not a bit
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign stop_ok   = stop_det & ~start_hi_r;

  // Byte boundaries
  assign byte_end  = scl_fall && (bit_cnt_r == BIT_LAST);
  assign addr_done = (state_r == TWCP_ADDR) && byte_end;
  assign addr_ok   = addr_done && addr_hit(rx_sh_r);
  assign tx_load   = scl_fall && (((state_r == TWCP_ACK) && rw_r) ||
                                  ((state_r == TWCP_TXACK) && mack_r));

  // Remembers a START until the clock drops, masking a STOP in that pulse
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_hi_r <= 1'b0;
    end else if (ce_in) begin
      if (start_det) begin
        start_hi_r <= 1'b1;
      end else if (scl_fall) begin
        start_hi_r <= 1'b0;
      end
    end
  end

  // Frame tracking tells a plain START from a repeated one
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_frame_r <= 1'b0;
      rep_r      <= 1'b0;
    end else if (ce_in) begin
      if (start_det) begin
        in_frame_r <= 1'b1;
        rep_r      <= in_frame_r;
      end else if (stop_ok) begin
        in_frame_r <= 1'b0;
        rep_r      <= 1'b0;
      end
    end
  end

  // Main sequencer; conditions take priority over bit activity
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r   <= TWCP_IDLE;
      bit_cnt_r <= BIT_NONE;
    end else if (ce_in) begin
      if (start_det) begin
        state_r   <= TWCP_ADDR;
        bit_cnt_r <= BIT_NONE;
      end else if (stop_ok) begin
        state_r   <= TWCP_IDLE;
        bit_cnt_r <= BIT_NONE;
      end else begin
        unique case (state_r)
          TWCP_IDLE: begin
            bit_cnt_r <= BIT_NONE;
          end
          TWCP_ADDR: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + BIT_ONE;
            end else if (addr_done) begin
              state_r <= addr_ok ? TWCP_ACK : TWCP_SKIP;
            end
          end
          TWCP_ACK: begin
            if (scl_fall) begin
              state_r   <= rw_r ? TWCP_TX : TWCP_RX;
              bit_cnt_r <= rw_r ? BIT_ONE : BIT_NONE;
            end
          end
          TWCP_RX: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + BIT_ONE;
            end else if (byte_end) begin
              state_r <= TWCP_ACK;
            end
          end
          TWCP_TX: begin
            if (byte_end) begin
              state_r <= TWCP_TXACK;
            end else if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + BIT_ONE;
            end
          end
          TWCP_TXACK: begin
            if (scl_fall) begin
              // Not-acknowledge ends the read; wait for STOP or START
              state_r   <= mack_r ? TWCP_TX : TWCP_SKIP;
              bit_cnt_r <= BIT_ONE;
            end
          end
          TWCP_SKIP: begin
            bit_cnt_r <= BIT_NONE;
          end
          default: begin
            state_r   <= TWCP_IDLE;
            bit_cnt_r <= BIT_NONE;
          end
        endcase
      end
    end
  end

  // Receive shifter, MSB first, sampled on clock rise
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_sh_r <= REG_RST;
    end else if (ce_in) begin
      if (scl_rise && ((state_r == TWCP_ADDR) || (state_r == TWCP_RX))) begin
        rx_sh_r <= {rx_sh_r[6:0], sda_s};
      end
    end
  end

  // Direction latched from the address byte
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rw_r <= 1'b0;
    end else if (ce_in) begin
      if (addr_done) begin
        rw_r <= rx_sh_r[0] == DIR_READ;
      end
    end
  end

  // Master acknowledge sampled on the ninth rise of a read byte
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mack_r <= 1'b0;
    end else if (ce_in) begin
      if ((state_r == TWCP_TXACK) && scl_rise) begin
        mack_r <= ~sda_s;
      end
    end
  end

  // Register pointer: loaded by the first written byte, reset by a plain
  // START read, advanced after every byte stored and as every byte to be sent is loaded
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_r     <= PTR_RST;
      ptr_set_r <= 1'b0;
    end else if (ce_in) begin
      if (addr_ok) begin
        ptr_set_r <= 1'b0;
        if ((rx_sh_r[0] == DIR_READ) && !rep_r) begin
          ptr_r <= PTR_RST;
        end
      end else if ((state_r == TWCP_RX) && byte_end) begin
        if (!ptr_set_r) begin
          ptr_r     <= rx_sh_r;
          ptr_set_r <= 1'b1;
        end else begin
          ptr_r <= ptr_r + PTR_STEP;
        end
      end else if (tx_load) begin
        ptr_r <= ptr_r + PTR_STEP;
      end
    end
  end

  // Register access; the write lands on the same edge the pointer moves
  assign rif.addr  = ptr_r;
  assign rif.wdata = rx_sh_r;
  assign rif.wr_en = (state_r == TWCP_RX) && byte_end && ptr_set_r;

  // Transmit shifter; the top bit goes out as the byte is loaded
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_sh_r <= REG_RST;
    end else if (ce_in) begin
      if (tx_load) begin
        tx_sh_r <= {rif.rdata[6:0], 1'b0};
      end else if ((state_r == TWCP_TX) && scl_fall && !byte_end) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  // Data line pull-down; changes only after clock falls so data is
  // steady for the whole clock-high time
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_oe_r <= 1'b0;
    end else if (ce_in) begin
      if (start_det || stop_ok) begin
        sda_oe_r <= 1'b0;
      end else if (addr_done) begin
        sda_oe_r <= addr_ok;
      end else if ((state_r == TWCP_RX) && byte_end) begin
        sda_oe_r <= 1'b1;
      end else if (tx_load) begin
        sda_oe_r <= ~rif.rdata[7];
      end else if ((state_r == TWCP_TX) && scl_fall) begin
        sda_oe_r <= byte_end ? 1'b0 : ~tx_sh_r[7];
      end else if (((state_r == TWCP_ACK) || (state_r == TWCP_TXACK)) && scl_fall) begin
        sda_oe_r <= 1'b0;
      end
    end
  end

  // Pad drive: output level fixed low, only the enable moves
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (ce_in) begin
      sda_out    <= 1'b0;
      sda_oe_out <= sda_oe_r;
    end
  end

  // Busy indication while a matched transfer is in progress
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addressed_out <= 1'b0;
    end else if (ce_in) begin
      addressed_out <= (state_r != TWCP_IDLE) && (state_r != TWCP_SKIP) &&
                       (state_r != TWCP_ADDR);
    end
  end

  // Power enables; shutdown wins over all, converters need the core
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      full_shutdown_out   <= 1'b0;
      digital_core_on_out <= 1'b0;
      line_out_on_out     <= 1'b0;
      left_dac_on_out     <= 1'b0;
      right_dac_on_out    <= 1'b0;
      left_adc_on_out     <= 1'b0;
      right_adc_on_out    <= 1'b0;
    end else if (ce_in) begin
      full_shutdown_out   <= rif.pwr[PWR_FULL_SHUTDOWN_BIT];
      digital_core_on_out <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.pwr[PWR_DIG_BIT];
      line_out_on_out     <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.pwr[PWR_LOUT_BIT];
      left_dac_on_out     <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.pwr[PWR_DIG_BIT]
                             & rif.pwr[PWR_DAL_BIT];
      right_dac_on_out    <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.pwr[PWR_DIG_BIT]
                             & rif.pwr[PWR_DAR_BIT];
      left_adc_on_out     <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.pwr[PWR_DIG_BIT]
                             & rif.pwr[PWR_ADL_BIT];
      right_adc_on_out    <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.pwr[PWR_DIG_BIT]
                             & rif.pwr[PWR_ADR_BIT];
    end
  end

  // Load-sense pin selects; all-zero field leaves every pin off
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      jack_sense_pin_sense_out   <= 1'b0;
      right_phones_out_sense_out <= 1'b0;
      left_phones_out_sense_out  <= 1'b0;
    end else if (ce_in) begin
      jack_sense_pin_sense_out   <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.lsns[LSNS_JACK_BIT];
      right_phones_out_sense_out <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.lsns[LSNS_HPR_BIT];
      left_phones_out_sense_out  <= ~rif.pwr[PWR_FULL_SHUTDOWN_BIT] & rif.lsns[LSNS_HPL_BIT];
    end
  end

endmodule

// File: inc/twcp_pkg.sv
// Constants, field layouts and state encoding for the two-wire control port
package twcp_pkg;

  // System clock and fastest legal bus clock
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned SCL_MAX_HZ = 400_000;

  // Fixed 7-bit device address and direction bit value
  localparam logic [6:0] DEV_ADDR = 7'h10;
  localparam logic       DIR_READ = 1'b1;

  // Register map
  localparam int unsigned REG_DW    = 8;
  localparam int unsigned REG_COUNT = 29;
  localparam logic [7:0]  LSNS_ADDR = 8'h1B;
  localparam logic [7:0]  PWR_ADDR  = 8'h1C;
  localparam logic [7:0]  LAST_ADDR = 8'h1C;
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [7:0]  PTR_RST   = 8'h00;
  localparam logic [7:0]  PTR_STEP  = 8'h01;
  localparam logic [7:0]  RD_NONE   = 8'h00;

  // Writable-bit masks; zero bits read back as zero
  localparam logic [7:0] MASK_ALL  = 8'hFF;
  localparam logic [7:0] MASK_LSNS = 8'h0F;
  localparam logic [7:0] MASK_PWR  = 8'hBF;

  // Power register fields
  localparam int unsigned PWR_FULL_SHUTDOWN_BIT = 7;
  localparam int unsigned PWR_DIG_BIT  = 5;
  localparam int unsigned PWR_LOUT_BIT = 4;
  localparam int unsigned PWR_DAL_BIT  = 3;
  localparam int unsigned PWR_DAR_BIT  = 2;
  localparam int unsigned PWR_ADL_BIT  = 1;
  localparam int unsigned PWR_ADR_BIT  = 0;

  // Load-sense select field in register 0x1B
  localparam int unsigned LSNS_JACK_BIT = 2;
  localparam int unsigned LSNS_HPR_BIT  = 1;
  localparam int unsigned LSNS_HPL_BIT  = 0;

  // Bit counting within a byte
  localparam logic [3:0] BIT_NONE = 4'h0;
  localparam logic [3:0] BIT_ONE  = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // Protocol states, Gray coded along address, ack and data path
  typedef enum logic [2:0] {
    TWCP_IDLE  = 3'h0,
    TWCP_ADDR  = 3'h1,
    TWCP_ACK   = 3'h3,
    TWCP_RX    = 3'h2,
    TWCP_TX    = 3'h7,
    TWCP_TXACK = 3'h6,
    TWCP_SKIP  = 3'h5
  } twcp_state_e;

endpackage

// File: inc/twcp_reg_if.sv
// Link between protocol engine and register storage
`timescale 1ns/100ps
interface twcp_reg_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] pwr;
  logic [7:0] lsns;

  modport ctl (output wr_en, output addr, output wdata, input rdata, input pwr, input lsns);
  modport rf  (input wr_en, input addr, input wdata, output rdata, output pwr, output lsns);
endinterface

// File: src/twcp_sync.sv
// Two-flop synchroniser for the bus pins
`timescale 1ns/100ps
module twcp_sync #(
  parameter int unsigned     W       = 2,
  parameter logic [W-1:0]    RST_VAL = '1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  // Lines idle high, so reset to high avoids a false START
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end else if (ce_in) begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// File: src/twcp_regfile.sv
// Configuration register storage, flip-flops indexed by address
`timescale 1ns/100ps
module twcp_regfile
  import twcp_pkg::*;
#(
  parameter int unsigned NREG = REG_COUNT
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  twcp_reg_if.rf    bus
);
  localparam int unsigned IW = $clog2(NREG);

  logic [REG_DW-1:0] mem_r [NREG];

  // Writable bits per address
  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    if (a == PWR_ADDR) begin
      return MASK_PWR;
    end else if (a == LSNS_ADDR) begin
      return MASK_LSNS;
    end
    return MASK_ALL;
  endfunction

  // Addresses past the map are dropped, not aliased
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NREG; i++) begin
        mem_r[i] <= REG_RST;
      end
    end else if (ce_in && bus.wr_en && bus.addr <= LAST_ADDR) begin
      mem_r[bus.addr[IW-1:0]] <= bus.wdata & reg_mask(bus.addr);
    end
  end

  // Read port and fixed taps
  assign bus.rdata = (bus.addr <= LAST_ADDR) ? mem_r[bus.addr[IW-1:0]] : RD_NONE;
  assign bus.pwr   = mem_r[PWR_ADDR[IW-1:0]];
  assign bus.lsns  = mem_r[LSNS_ADDR[IW-1:0]];
endmodule

// File: tb/twcp_chk.sv
// Concurrent checks on the two-wire control port pins and enables
`timescale 1ns/100ps
module twcp_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic full_shutdown_out,
  input wire logic digital_core_on_out,
  input wire logic line_out_on_out,
  input wire logic left_dac_on_out,
  input wire logic right_dac_on_out,
  input wire logic left_adc_on_out,
  input wire logic right_adc_on_out,
  input wire logic jack_sense_pin_sense_out,
  input wire logic right_phones_out_sense_out,
  input wire logic left_phones_out_sense_out,
  input wire logic addressed_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_shutdown_wins: assert property (
    full_shutdown_out |-> !(digital_core_on_out || line_out_on_out || jack_sense_pin_sense_out
      || right_phones_out_sense_out || left_phones_out_sense_out)) else $error("enable on in shutdown");
  chk_core_gates_conv: assert property (
    (left_dac_on_out || right_dac_on_out || left_adc_on_out || right_adc_on_out) |-> digital_core_on_out)
    else $error("converter on without core");
  chk_sda_only_low: assert property (
    sda_oe_out |-> !sda_out) else $error("data line driven high");
  chk_stop_ends_frame: assert property (
    scl_in && $rose(sda_in) |-> ##[1:8] !addressed_out) else $error("stop did not end frame");
  chk_sda_moves_low: assert property (
    $changed(sda_oe_out) |-> !scl_in) else $error("data drive changed with clock high");
  chk_drive_held_high: assert property (
    $rose(scl_in) && sda_oe_out |-> sda_oe_out [*8]) else $error("drive dropped in clock high");
  chk_drive_needs_match: assert property (
    sda_oe_out && $past(sda_oe_out, 8) |-> addressed_out) else $error("drive without address match");
  chk_enables_by_frame: assert property (
    $changed({digital_core_on_out, line_out_on_out, full_shutdown_out}) |-> addressed_out)
    else $error("enables moved outside a frame");
endmodule

bind twcp_top twcp_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .full_shutdown_out(full_shutdown_out),
  .digital_core_on_out(digital_core_on_out), .line_out_on_out(line_out_on_out),
  .left_dac_on_out(left_dac_on_out), .right_dac_on_out(right_dac_on_out),
  .left_adc_on_out(left_adc_on_out), .right_adc_on_out(right_adc_on_out),
  .jack_sense_pin_sense_out(jack_sense_pin_sense_out), .right_phones_out_sense_out(right_phones_out_sense_out),
  .left_phones_out_sense_out(left_phones_out_sense_out), .addressed_out(addressed_out));

// File: tb/twcp_master.sv
// Behavioural two-wire bus master driving clock and open-drain data
`timescale 1ns/100ps
module twcp_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // Half period of 64 clocks keeps the bus near 390 kHz, under the limit
  localparam int PH = 64;
  // Master alone makes the clock; idles high between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data moves only in clock low, sampled just before the fall
  task automatic bit_io(input logic b, output logic s);
    sda_low_out <= ~b;
    wt(PH / 2);
    scl_out <= 1'b1;
    wt(PH);
    s = sda_in;
    scl_out <= 1'b0;
    wt(PH / 2);
  endtask
  // Start keeps a full clock high apart from any stop
  task automatic start();
    sda_low_out <= 1'b1;
    wt(PH / 2);
    scl_out <= 1'b0;
    wt(PH / 2);
  endtask
  task automatic rstart();
    sda_low_out <= 1'b0;
    wt(PH / 2);
    scl_out <= 1'b1;
    wt(PH / 2);
    start();
  endtask
  task automatic stop();
    sda_low_out <= 1'b1;
    wt(PH / 2);
    scl_out <= 1'b1;
    wt(PH / 2);
    sda_low_out <= 1'b0;
    wt(PH);
  endtask
  // Eight bits MSB first, then the acknowledge clock is watched
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Acknowledge each byte but the last, which gets a not-acknowledge
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the two-wire control port
`timescale 1ns/100ps
module tb_top;
  import twcp_pkg::*;
  logic       clk_in, rst_in, ce_in, scl, sda_low, sda_out, sda_oe_out, addressed, a;
  wire logic [9:0] outs;
  logic [7:0] d, pv, lv;
  logic [7:0] mdl [0:28];
  logic [7:0] q [$];
  int         mismatches, check_count, seed, p;
  int         cyc = 0;
  // Pull-up on data; either party may only pull it low
  wire logic sda_wire = !(sda_oe_out && !sda_out) && !sda_low;
  twcp_top u_twcp_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .full_shutdown_out(outs[9]), .digital_core_on_out(outs[8]),
    .line_out_on_out(outs[7]), .left_dac_on_out(outs[6]), .right_dac_on_out(outs[5]),
    .left_adc_on_out(outs[4]), .right_adc_on_out(outs[3]), .jack_sense_pin_sense_out(outs[2]),
    .right_phones_out_sense_out(outs[1]), .left_phones_out_sense_out(outs[0]), .addressed_out(addressed));
  twcp_master u_twcp_master (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Readable bits per address; bit 6 of power and upper load-sense bits stay zero
  function automatic logic [7:0] wmask(input int r);
    return (r == LSNS_ADDR) ? MASK_LSNS : (r == PWR_ADDR) ? MASK_PWR : MASK_ALL;
  endfunction
  // Expected enables: shutdown beats all, converters need the core
  function automatic logic [9:0] outs_exp(input logic [7:0] pw, input logic [7:0] ls);
    logic sd, core;
    sd = pw[7];
    core = pw[5] & ~sd;
    return {sd, core, pw[4] & ~sd, pw[3] & core, pw[2] & core, pw[1] & core, pw[0] & core, ls[2:0] & {3{~sd}}};
  endfunction
  task automatic wr_frame(input int r);
    u_twcp_master.start();
    u_twcp_master.send_byte({DEV_ADDR, 1'b0}, a);
    chk({9'h0, a}, 10'h1);
    u_twcp_master.send_byte(8'(r), a);
    chk({9'h0, a}, 10'h1);
    foreach (q[i]) begin
      u_twcp_master.send_byte(q[i], a);
      chk({9'h0, a}, 10'h1);
      mdl[r + i] = q[i] & wmask(r + i);
    end
    u_twcp_master.stop();
  endtask
  // Negative start reads from a plain start, else pointer is preset first
  task automatic rd_frame(input int r, input int n);
    int b;
    b = (r < 0) ? 0 : r;
    u_twcp_master.start();
    if (r >= 0) begin
      u_twcp_master.send_byte({DEV_ADDR, 1'b0}, a);
      u_twcp_master.send_byte(8'(r), a);
      u_twcp_master.rstart();
    end
    u_twcp_master.send_byte({DEV_ADDR, DIR_READ}, a);
    chk({9'h0, a}, 10'h1);
    for (int i = 0; i < n; i++) begin
      u_twcp_master.recv_byte(i == n - 1, d);
      chk({2'h0, d}, {2'h0, mdl[b + i]});
    end
    u_twcp_master.stop();
  endtask
  // Hang guard reckoned from about 63 bytes at 1152 clocks each
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 85000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    seed = 85839;
    mismatches = 0;
    check_count = 0;
    ce_in = 1'b1;
    rst_in = 1'b1;
    foreach (mdl[i]) mdl[i] = REG_RST;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk(outs, 10'h0);
    rd_frame(-1, 3);
    $display("test reset_read done");
    // Random bursts to random pointers, read back through a preset pointer
    repeat (2) begin
      p = $unsigned($random(seed)) % 24;
      q = {};
      repeat (4) q.push_back(8'($random(seed)));
      wr_frame(p);
      rd_frame(p, 4);
    end
    rd_frame(-1, 2);
    $display("test burst done");
    // Power and load-sense table, corner values then random
    for (int i = 0; i < 4; i++) begin
      pv = (i == 0) ? 8'hBF : (i == 1) ? 8'h7F : (i == 2) ? 8'h1F : 8'($random(seed));
      lv = (i == 0) ? 8'h07 : (i == 1) ? 8'h04 : (i == 2) ? 8'h03 : 8'($random(seed));
      q = {lv, pv};
      wr_frame(LSNS_ADDR);
      repeat (2) @(posedge clk_in);
      chk(outs, outs_exp(pv, lv));
    end
    rd_frame(LSNS_ADDR, 2);
    $display("test power done");
    // Foreign address is neither acknowledged nor followed
    u_twcp_master.start();
    u_twcp_master.send_byte(8'h22, a);
    chk({9'h0, a}, 10'h0);
    u_twcp_master.send_byte(8'h00, a);
    chk({8'h0, a, addressed}, 10'h0);
    u_twcp_master.stop();
    $display("test foreign done");
    // Stop in mid data byte leaves the register untouched
    u_twcp_master.start();
    u_twcp_master.send_byte({DEV_ADDR, 1'b0}, a);
    u_twcp_master.send_byte(8'h02, a);
    repeat (3) u_twcp_master.bit_io(~mdl[2][7], a);
    chk({9'h0, addressed}, 10'h1);
    u_twcp_master.stop();
    chk({9'h0, addressed}, 10'h0);
    rd_frame(2, 1);
    $display("test early_stop done");
    summarize();
  end
endmodule
